// file: design/eac_pkg.sv
`default_nettype none
package eac_pkg;
    // ------------------------------------------------------------
    // Register offsets (I/O space)
    // ------------------------------------------------------------
    localparam logic [5:0] EAC_ADDR_LOW_OFS = 6'h21;
    localparam logic [5:0] EAC_ADDR_HIGH_OFS = 6'h22;
    localparam logic [5:0] EAC_DATA_OFS = 6'h20;
    localparam logic [5:0] EAC_CONTROL_OFS = 6'h1f;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int EAC_BIT_READ = 0;
    localparam int EAC_BIT_WRITE = 1;
    localparam int EAC_BIT_ARM = 2;
    localparam int EAC_BIT_IRQEN = 3;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] EAC_CONTROL_RST = 8'h00;
    localparam logic [7:0] EAC_DATA_RST = 8'h00;
    localparam logic [10:0] EAC_ADDR_RST = 11'h000;
    localparam logic [2:0] EAC_ARM_CYCLES = 3'h4;
    localparam logic [2:0] EAC_READ_STALL = 3'h4;
    localparam logic [2:0] EAC_WRITE_STALL = 3'h2;
    localparam int EAC_PROG_RC_CYCLES = 27072;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EAC_IDLE = 3'b001,
        EAC_PROG = 3'b010,
        EAC_DONE = 3'b100
    } eac_state_type;
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } eac_io_req_type;
    typedef struct packed {
        logic we;
        logic [10:0] addr;
        logic [7:0] wdata;
    } eac_mem_req_type;
endpackage
`default_nettype wire

// file: design/eac_array.sv
`default_nettype none
module eac_array #(
    parameter int ADDR_W = 11
) (
    input wire logic core_clk_in,
    input wire eac_pkg::eac_mem_req_type req_in,
    output logic [7:0] rdata_out
);
    import eac_pkg::*;
    logic [7:0] mem [0:(1 << ADDR_W) - 1];
    // Array cells carry no reset; read data is registered
    always_ff @(posedge core_clk_in) begin
        if (req_in.we) begin
            mem[req_in.addr[ADDR_W-1:0]] <= req_in.wdata;
        end
        rdata_out <= mem[req_in.addr[ADDR_W-1:0]];
    end
endmodule
`default_nettype wire

// file: design/eac_ctrl.sv
`default_nettype none
// Behaviour
// - Smallest array: 9-bit address 0..511, bits 15:9 read zero.
// - Larger arrays: address bits 10:0, bits 15:11 read zero.
// - Address has no meaningful reset value; software loads it first.
// - Data register holds write byte, and read byte after a read.
// - Bit 3 enables ready interrupt, gated by global flag, while strobe clear.
// - Arm bit 2 self-clears four cycles after set; strobe inside starts write.
// - Write strobe with arm clear is ignored.
// - Write strobe is bit 1; it writes the data byte at the address.
// - Read strobe bit 0 fetches the byte for the next instruction.
// - A read stalls the processor four cycles.
// - Write continues through power-down; its clock keeps running after. Here prog_clock_request_out drops with the strobe bit.
// - Reset during a write does not abort programming.
// - Write strobe clears when the self-timed duration elapses.
// - During a write, array reads and address changes are blocked.
// - Starting a write stalls the processor two cycles.
// - No write start while flash self-programming is busy.
module eac_ctrl #(
    parameter int ADDR_W = 11,
    parameter int PROG_CYCLES = eac_pkg::EAC_PROG_RC_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic prog_clk_tick_in,
    input wire eac_pkg::eac_io_req_type io_req_in,
    input wire logic global_irq_enable_in,
    input wire logic flash_selfprog_busy_in,
    output logic [7:0] io_rdata_out,
    output logic cpu_stall_out,
    output logic ready_irq_out,
    output logic prog_clock_request_out
);
    import eac_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        eac_state_type st;
        logic [10:0] addr;
        logic [7:0] data;
        logic irqen;
        logic arm;
        logic [2:0] arm_cnt;
        logic [2:0] stall_cnt;
        logic [15:0] prog_cnt;
        logic rd_pend;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        logic [7:0] rdata;
    } eac_regs_type;

    eac_regs_type r_q;
    eac_regs_type r_d;
    logic [7:0] arr_rdata;
    eac_mem_req_type mreq;
    logic busy;
    logic tick_edge;
    logic [10:0] addr_mask;
    logic [7:0] rd_mux;
    logic prog_hold_q;
    logic [15:0] prog_cnt_sh_q;
    logic [10:0] prog_addr_q;
    logic [7:0] prog_data_q;
    logic [2:0] sh_tick_q;
    logic sh_edge;
    logic orphan;
    logic sh_we;

    // Busy also covers a write that outlived a reset
    assign busy = (r_q.st != EAC_IDLE) | prog_hold_q;
    assign tick_edge = r_q.tick_s2 & ~r_q.tick_s3;
    assign addr_mask = 11'((1 << ADDR_W) - 1);

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    eac_array #(
        .ADDR_W(ADDR_W)
    ) u_array (
        .core_clk_in(core_clk_in),
        .req_in(mreq),
        .rdata_out(arr_rdata)
    );

    always_comb begin
        mreq.we = (r_q.st == EAC_DONE) | sh_we;
        mreq.addr = sh_we ? prog_addr_q : r_q.addr;
        mreq.wdata = sh_we ? prog_data_q : r_q.data;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.tick_s1 = prog_clk_tick_in;
        r_d.tick_s2 = r_q.tick_s1;
        r_d.tick_s3 = r_q.tick_s2;
        if (r_q.stall_cnt != 3'h0) begin
            r_d.stall_cnt = r_q.stall_cnt - 3'h1;
        end
        // Arming window
        if (r_q.arm) begin
            if (r_q.arm_cnt == 3'h1) begin
                r_d.arm = 1'b0;
            end
            r_d.arm_cnt = r_q.arm_cnt - 3'h1;
        end
        // Read data lands one cycle after strobe, inside the stall
        if (r_q.rd_pend) begin
            r_d.data = arr_rdata;
            r_d.rd_pend = 1'b0;
        end
        unique case (r_q.st)
            EAC_IDLE: begin
            end
            EAC_PROG: begin
                if (tick_edge) begin
                    if (r_q.prog_cnt == 16'(PROG_CYCLES - 1)) begin
                        r_d.st = EAC_DONE;
                    end else begin
                        r_d.prog_cnt = r_q.prog_cnt + 16'h1;
                    end
                end
            end
            EAC_DONE: begin
                r_d.st = EAC_IDLE;
            end
        endcase
        if (io_req_in.sel && io_req_in.wr) begin
            unique case (io_req_in.addr)
                EAC_ADDR_LOW_OFS: begin
                    if (!busy) begin
                        r_d.addr[7:0] = io_req_in.wdata;
                    end
                end
                EAC_ADDR_HIGH_OFS: begin
                    if (!busy) begin
                        r_d.addr[10:8] = io_req_in.wdata[2:0] & addr_mask[10:8];
                    end
                end
                EAC_DATA_OFS: begin
                    r_d.data = io_req_in.wdata;
                end
                EAC_CONTROL_OFS: begin
                    r_d.irqen = io_req_in.wdata[EAC_BIT_IRQEN];
                    if (io_req_in.wdata[EAC_BIT_ARM] && !r_q.arm) begin
                        r_d.arm = 1'b1;
                        r_d.arm_cnt = EAC_ARM_CYCLES;
                    end
                    if (io_req_in.wdata[EAC_BIT_WRITE] && !busy && r_q.arm
                        && !flash_selfprog_busy_in) begin
                        r_d.st = EAC_PROG;
                        r_d.prog_cnt = 16'h0;
                        r_d.arm = 1'b0;
                        r_d.stall_cnt = EAC_WRITE_STALL;
                    end else if (io_req_in.wdata[EAC_BIT_READ] && !busy) begin
                        r_d.rd_pend = 1'b1;
                        r_d.stall_cnt = EAC_READ_STALL;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers; programming is not aborted by reset
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r_q.st <= EAC_IDLE;
            r_q.addr <= EAC_ADDR_RST;
            r_q.data <= EAC_DATA_RST;
            r_q.irqen <= 1'b0;
            r_q.arm <= 1'b0;
            r_q.arm_cnt <= 3'h0;
            r_q.stall_cnt <= 3'h0;
            r_q.prog_cnt <= 16'h0;
            r_q.rd_pend <= 1'b0;
            r_q.tick_s1 <= 1'b0;
            r_q.tick_s2 <= 1'b0;
            r_q.tick_s3 <= 1'b0;
            r_q.rdata <= 8'h00;
        end else begin
            r_q <= r_d;
            r_q.rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Reset-immune write engine: finishes a write cut by reset
    // ------------------------------------------------------------
    assign sh_edge = sh_tick_q[1] & ~sh_tick_q[2];
    assign orphan = prog_hold_q & (r_q.st == EAC_IDLE);
    assign sh_we = orphan & sh_edge & (prog_cnt_sh_q == 16'(PROG_CYCLES - 1));

    always_ff @(posedge core_clk_in) begin
        sh_tick_q <= {sh_tick_q[1:0], prog_clk_tick_in};
        if (r_q.st == EAC_PROG) begin
            prog_hold_q <= 1'b1;
            prog_cnt_sh_q <= r_q.prog_cnt;
            prog_addr_q <= r_q.addr;
            prog_data_q <= r_q.data;
        end else if (orphan && !sh_we) begin
            prog_hold_q <= 1'b1;
            if (sh_edge) begin
                prog_cnt_sh_q <= prog_cnt_sh_q + 16'h1;
            end
        end else begin
            prog_hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        if (io_req_in.sel && io_req_in.rd) begin
            unique case (io_req_in.addr)
                EAC_ADDR_LOW_OFS: rd_mux = r_q.addr[7:0];
                EAC_ADDR_HIGH_OFS: rd_mux = {5'h00, r_q.addr[10:8] & addr_mask[10:8]};
                EAC_DATA_OFS: rd_mux = r_q.data;
                EAC_CONTROL_OFS: begin
                    rd_mux = {4'h0, r_q.irqen, r_q.arm, busy, 1'b0};
                end
                default: rd_mux = 8'h00;
            endcase
        end
    end

    assign io_rdata_out = r_q.rdata;
    assign cpu_stall_out = (r_q.stall_cnt != 3'h0);
    assign ready_irq_out = r_q.irqen & global_irq_enable_in & ~busy;
    assign prog_clock_request_out = busy | prog_hold_q;
endmodule
`default_nettype wire

// file: bench/eac_rc_osc.sv
`default_nettype none
module eac_rc_osc (
    input wire logic run_in,
    output logic tick_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Runs while run_in is high: the programming timer keeps ticking after a write ends
    initial begin
        tick_out = 1'b0;
        forever #62.5 tick_out = run_in ? ~tick_out : tick_out;
    end
endmodule
`default_nettype wire

// file: bench/eac_ctrl_asserts.sv
`default_nettype none
module eac_ctrl_asserts #(
    parameter int ADDR_W = 11,
    parameter int PROG_CYCLES = eac_pkg::EAC_PROG_RC_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic prog_clk_tick_in,
    input wire eac_pkg::eac_io_req_type io_req_in,
    input wire logic global_irq_enable_in,
    input wire logic flash_selfprog_busy_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic cpu_stall_out,
    input wire logic ready_irq_out,
    input wire logic prog_clock_request_out
);
    import eac_pkg::*;
    logic ctl_wr, arm_wr, stb_wr, rd_go, busy, rd_req;
    assign ctl_wr = io_req_in.sel && io_req_in.wr && io_req_in.addr == EAC_CONTROL_OFS;
    assign arm_wr = ctl_wr && io_req_in.wdata[EAC_BIT_ARM];
    assign stb_wr = ctl_wr && io_req_in.wdata[EAC_BIT_WRITE];
    assign rd_go = ctl_wr && io_req_in.wdata[EAC_BIT_READ] && !io_req_in.wdata[EAC_BIT_WRITE];
    assign busy = prog_clock_request_out;
    assign rd_req = io_req_in.sel && io_req_in.rd;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_arm;
        arm_wr && !stb_wr && !busy && !cpu_stall_out;
    endsequence
    sequence s_no_arm;
        (!busy && !arm_wr) [*5];
    endsequence
    AST_WRITE_STALL: assert property (s_arm ##1 stb_wr && !flash_selfprog_busy_in
        |=> cpu_stall_out [*2] ##1 !cpu_stall_out) else $error("write stall length wrong");
    AST_WRITE_START: assert property (s_arm ##1 stb_wr && !flash_selfprog_busy_in
        |=> busy) else $error("armed strobe did not start programming");
    AST_FLASH_BLOCK: assert property (s_arm ##1 stb_wr && flash_selfprog_busy_in
        |=> !busy) else $error("write started while flash busy");
    AST_NO_ARM: assert property (s_no_arm ##1 stb_wr && !io_req_in.wdata[EAC_BIT_ARM]
        |=> !busy) else $error("unarmed strobe started programming");
    AST_READ_STALL: assert property (rd_go && !busy && !cpu_stall_out
        |=> cpu_stall_out [*4] ##1 !cpu_stall_out) else $error("read stall length wrong");
    AST_RDATA_IDLE: assert property (!rd_req |=> io_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    AST_ADDR_HIGH_RSV: assert property (rd_req && io_req_in.addr == EAC_ADDR_HIGH_OFS
        |=> (io_rdata_out >> (ADDR_W - 8)) == 8'h00) else $error("reserved address bits set");
    AST_IRQ_GATE: assert property (ready_irq_out |-> global_irq_enable_in && !busy)
        else $error("ready interrupt without its conditions");
endmodule
bind eac_ctrl eac_ctrl_asserts #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_asserts (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .prog_clk_tick_in(prog_clk_tick_in),
    .io_req_in(io_req_in), .global_irq_enable_in(global_irq_enable_in),
    .flash_selfprog_busy_in(flash_selfprog_busy_in), .io_rdata_out(io_rdata_out),
    .cpu_stall_out(cpu_stall_out), .ready_irq_out(ready_irq_out),
    .prog_clock_request_out(prog_clock_request_out));
`default_nettype wire

// file: bench/eeprom_access_controller_test.sv
`default_nettype none
module eeprom_access_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import eac_pkg::*;
    logic core_clk_in, nrst_in, tick, gie, fbusy, stall, irq, preq;
    eac_io_req_type req;
    logic [7:0] rdata, got;
    int n_fail, n_compared;
    eac_ctrl #(.ADDR_W(9), .PROG_CYCLES(8)) dut (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .prog_clk_tick_in(tick),
        .io_req_in(req), .global_irq_enable_in(gie), .flash_selfprog_busy_in(fbusy),
        .io_rdata_out(rdata), .cpu_stall_out(stall), .ready_irq_out(irq),
        .prog_clock_request_out(preq));
    eac_rc_osc osc (.run_in(1'b1), .tick_out(tick));
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        req <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask
    task automatic idle(input int n);
        @(posedge core_clk_in);
        req <= '0;
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        req <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_in);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 100; i++) begin
            rd(EAC_CONTROL_OFS, got);
            if (got[EAC_BIT_WRITE] === 1'b0) break;
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        nrst_in = 1'b0;
        req = '0;
        gie = 1'b0;
        fbusy = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        rd(EAC_CONTROL_OFS, got);
        chk(got, EAC_CONTROL_RST, "control reset");
        wr(EAC_ADDR_HIGH_OFS, 8'hff);
        wr(EAC_ADDR_LOW_OFS, 8'h5a);
        idle(0);
        rd(EAC_ADDR_HIGH_OFS, got);
        chk(got, 8'h01, "address high");
        rd(EAC_ADDR_LOW_OFS, got);
        chk(got, 8'h5a, "address low");
        $display("Test address done");
        wr(EAC_CONTROL_OFS, 8'h08);
        gie <= 1'b1;
        idle(1);
        chk({7'h00, irq}, 8'h01, "irq ready");
        wr(EAC_DATA_OFS, 8'ha5);
        wr(EAC_CONTROL_OFS, 8'h0c);
        wr(EAC_CONTROL_OFS, 8'h0e);
        idle(3);
        chk({6'h00, preq, irq}, 8'h02, "busy irq and clock");
        rd(EAC_CONTROL_OFS, got);
        chk(got & 8'h02, 8'h02, "strobe busy");
        wr(EAC_ADDR_LOW_OFS, 8'h00);
        idle(0);
        rd(EAC_ADDR_LOW_OFS, got);
        chk(got, 8'h5a, "address locked");
        wait_ready();
        chk(got & 8'h06, 8'h00, "strobe cleared");
        #1 chk({7'h00, irq}, 8'h01, "irq after write");
        gie <= 1'b0;
        wr(EAC_DATA_OFS, 8'h3c);
        wr(EAC_CONTROL_OFS, 8'h09);
        idle(5);
        chk({7'h00, irq}, 8'h00, "irq gated");
        rd(EAC_DATA_OFS, got);
        chk(got, 8'ha5, "read back");
        $display("Test write and read done");
        wr(EAC_DATA_OFS, 8'h77);
        wr(EAC_CONTROL_OFS, 8'h02);
        wr(EAC_CONTROL_OFS, 8'h04);
        idle(6);
        wr(EAC_CONTROL_OFS, 8'h02);
        idle(1);
        fbusy <= 1'b1;
        wr(EAC_CONTROL_OFS, 8'h04);
        wr(EAC_CONTROL_OFS, 8'h06);
        idle(2);
        fbusy <= 1'b0;
        rd(EAC_CONTROL_OFS, got);
        chk(got & 8'h02, 8'h00, "refused strobes");
        wr(EAC_CONTROL_OFS, 8'h01);
        idle(5);
        rd(EAC_DATA_OFS, got);
        chk(got, 8'ha5, "array unchanged");
        $display("Test refused writes done");
        wr(EAC_ADDR_HIGH_OFS, 8'h00);
        wr(EAC_ADDR_LOW_OFS, 8'h33);
        wr(EAC_DATA_OFS, 8'hc3);
        wr(EAC_CONTROL_OFS, 8'h04);
        wr(EAC_CONTROL_OFS, 8'h06);
        idle(3);
        nrst_in <= 1'b0;
        idle(4);
        nrst_in <= 1'b1;
        idle(1);
        chk({7'h00, preq}, 8'h01, "write survives reset");
        wait_ready();
        chk(got & 8'h02, 8'h00, "strobe cleared after reset");
        wr(EAC_ADDR_HIGH_OFS, 8'h00);
        wr(EAC_ADDR_LOW_OFS, 8'h33);
        wr(EAC_CONTROL_OFS, 8'h01);
        idle(5);
        rd(EAC_DATA_OFS, got);
        chk(got, 8'hc3, "write completed across reset");
        $display("Test reset during write done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
